// ===== design/ars_pkg.sv
// Purpose: shared constants and carrier types for the application register state block
// Assumes: single clock, asynchronous active-high reset
// Notes:   frame marker layout and register file geometry live here
`default_nettype none
package ars_pkg;
	localparam int INT_ENTRIES    = 128;
	localparam int INT_WIDTH      = 64;
	localparam int FLT_ENTRIES    = 128;
	localparam int FLT_WIDTH      = 82;
	localparam int PRED_ENTRIES   = 64;
	localparam int BT_ENTRIES     = 8;
	localparam int BT_WIDTH       = 64;
	localparam int PTR_WIDTH      = 64;
	localparam int MARK_WIDTH     = 38;
	localparam int STATIC_LAST    = 31;
	localparam int PRED_STAT_LAST = 15;
	localparam int LEGACY_FIRST   = 8;
	localparam int LEGACY_LAST    = 31;
	// frame marker field positions
	localparam int SOF_LSB = 0;
	localparam int SOF_MSB = 6;
	localparam int SOL_LSB = 7;
	localparam int SOL_MSB = 13;
	localparam int SOR_LSB = 14;
	localparam int SOR_MSB = 17;
	localparam int RRB_INT_LSB = 18;
	localparam int RRB_INT_MSB = 24;
	localparam int RRB_FLT_LSB = 25;
	localparam int RRB_FLT_MSB = 31;
	localparam int RRB_PRD_LSB = 32;
	localparam int RRB_PRD_MSB = 37;
	localparam int ROT_PER_SOR = 8;
	localparam int BUNDLE_BYTES = 16;
	localparam int BUNDLE_LSBS  = 4;
	// reset values
	localparam logic [INT_WIDTH-1:0] INT_RST  = 64'h0000_0000_0000_0000;
	localparam logic [FLT_WIDTH-1:0] FLT_RST  = 82'h0_0000_0000_0000_0000_0000;
	localparam logic [PTR_WIDTH-1:0] PTR_RST  = 64'h0000_0000_0000_0000;
	localparam logic [MARK_WIDTH-1:0] MARK_RST = 38'h00_0000_0000;
	// constant floating entries: +0.0 and +1.0 (17-bit exponent, 64-bit significand)
	localparam logic [FLT_WIDTH-1:0] FLT_POS_ZERO = 82'h0_0000_0000_0000_0000_0000;
	localparam logic [FLT_WIDTH-1:0] FLT_POS_ONE  = 82'h0_FFFF_8000_0000_0000_0000;
	// deferred-exception encoding: exponent 1_FFFE, significand zero, sign zero
	localparam logic [FLT_WIDTH-1:0] FLT_DEFER_VAL = 82'h1_FFFE_0000_0000_0000_0000;

	typedef logic [MARK_WIDTH-1:0] ars_mark_t;

	// integer write request: value plus deferred-exception tag
	typedef struct packed {
		logic                  en;
		logic [6:0]            idx;
		logic [INT_WIDTH-1:0]  data;
		logic                  tag;
	} ars_int_wr_t;

	typedef struct packed {
		logic                  en;
		logic [6:0]            idx;
		logic [FLT_WIDTH-1:0]  data;
		logic                  defer;
	} ars_flt_wr_t;

	typedef struct packed {
		logic                  en;
		logic [5:0]            idx;
		logic                  data;
	} ars_prd_wr_t;

	typedef struct packed {
		logic                  en;
		logic [2:0]            idx;
		logic [BT_WIDTH-1:0]   data;
	} ars_bt_wr_t;

	// integer read answer
	typedef struct packed {
		logic [INT_WIDTH-1:0]  data;
		logic                  tag;
	} ars_int_rd_t;

	typedef struct packed {
		logic                  call;
		logic                  ret;
		ars_mark_t             restore;
		logic [6:0]            alloc_sof;
		logic [6:0]            alloc_sol;
		logic [3:0]            alloc_sor;
		logic                  alloc;
	} ars_frame_op_t;
endpackage : ars_pkg
`default_nettype wire

// ===== design/ars_core.sv
// Purpose: architectural application register state: integer, floating, predicate,
//          branch files, bundle pointer and current frame marker
// Assumes: the pipeline issues at most one write per file per cycle
// Notes:   reads are registered, one cycle of latency; faults are one-cycle pulses
`default_nettype none

// Contract
// RULE_01: integer file holds 128 entries of 64 bits plus a deferred-exception tag.
// RULE_02: integer entry zero reads zero; writing it raises an illegal operation fault.
// RULE_03: integer entries 0-31 static, 32-127 stacked in a sized, renameable frame.
// RULE_04: legacy mode keeps legacy integer and segment state in integer entries 8-31.
// RULE_05: floating file holds 128 entries of 82 bits, open to every privilege.
// RULE_06: floating entry zero reads +0.0, one reads +1.0; writing either faults.
// RULE_07: floating entries 0-31 static, 32-127 rotating under program control.
// RULE_08: legacy mode keeps legacy floating and multimedia state in entries 8-31.
// RULE_09: floating deferred exception stored as a special encoding, no tag bit.
// RULE_10: predicate file holds 64 one-bit entries from compares, qualifying execution.
// RULE_11: predicate entry zero reads one; writes to it dropped silently, no fault.
// RULE_12: predicates 0-15 static and branch-usable; 16-63 rotating, renameable.
// RULE_13: branch file holds 8 entries of 64 bits for indirect branch targets.
// RULE_14: bundle pointer readable, not writable; advances, changes by branches.
// RULE_15: native execution keeps bundle pointer low 4 bits zero.
// RULE_16: legacy execution keeps bundle pointer low 4 bits as byte address.
// RULE_17: frame marker never read or written directly; only frame operations change it.
// RULE_18: frame marker: frame size 6:0, locals 13:7, rotating size 17:14.
// RULE_19: frame marker rename bases: integer 24:18, floating 31:25, predicate 37:32.
// RULE_20: rotating integer entries equal eight times the rotating-size field.
// RULE_21: call copies frame marker to prior-function-state; new frame keeps caller outputs.
// RULE_22: call clears all three rename base fields.
// RULE_23: call frame size is caller size minus locals; locals and rotating size zero.
module ars_core (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         legacy_mode,
	input  wire logic [6:0]                   int_rd_idx,
	input  wire logic [6:0]                   flt_rd_idx,
	input  wire logic [5:0]                   prd_rd_idx,
	input  wire logic [2:0]                   bt_rd_idx,
	input  wire ars_pkg::ars_int_wr_t         int_wr,
	input  wire ars_pkg::ars_flt_wr_t         flt_wr,
	input  wire ars_pkg::ars_prd_wr_t         prd_wr,
	input  wire ars_pkg::ars_bt_wr_t          bt_wr,
	input  wire logic                         ptr_advance,
	input  wire logic [3:0]                   ptr_bytes,
	input  wire logic                         ptr_branch,
	input  wire logic [ars_pkg::PTR_WIDTH-1:0] ptr_target,
	input  wire ars_pkg::ars_frame_op_t       frame_op,
	output var ars_pkg::ars_int_rd_t          int_rd,
	output var logic [ars_pkg::FLT_WIDTH-1:0] flt_rd,
	output var logic                          flt_rd_deferred,
	output var logic                          prd_rd,
	output var logic [ars_pkg::BT_WIDTH-1:0]  bt_rd,
	output var logic [ars_pkg::PTR_WIDTH-1:0] bundle_pointer,
	output var ars_pkg::ars_mark_t            prior_function_state,
	output var logic [7:0]                    int_rotating_count,
	output var logic [6:0]                    int_rename_base,
	output var logic [6:0]                    float_rename_base,
	output var logic [5:0]                    pred_rename_base,
	output var logic                          int_write_fault,
	output var logic                          flt_write_fault
);
	import ars_pkg::*;

	// storage: plain flip-flop arrays indexed by entry number
	logic [INT_WIDTH-1:0] int_reg_q      [INT_ENTRIES];
	logic                 deferred_exception_tag_q [INT_ENTRIES];
	logic [FLT_WIDTH-1:0] float_reg_q    [FLT_ENTRIES];
	logic [PRED_ENTRIES-1:0] pred_reg_q;
	logic [PRED_ENTRIES-1:0] pred_reg_d;
	logic [BT_WIDTH-1:0]  branch_target_reg_q [BT_ENTRIES];

	logic [PTR_WIDTH-1:0] ptr_q;
	logic [PTR_WIDTH-1:0] ptr_d;
	ars_mark_t            current_frame_marker_q;
	ars_mark_t            current_frame_marker_d;
	ars_mark_t            prior_function_state_q;
	ars_mark_t            prior_function_state_d;

	ars_int_rd_t          int_rd_d;
	logic [FLT_WIDTH-1:0] flt_rd_d;
	logic                 flt_def_d;
	logic                 prd_rd_d;
	logic [BT_WIDTH-1:0]  bt_rd_d;
	logic                 int_fault_d;
	logic                 flt_fault_d;

	// per-entry integer storage; entry zero never stores (see RULE_02)
	// legacy integer and segment state shares entries 8-31, no remap (see RULE_04)
	for (genvar i = 0; i < INT_ENTRIES; i++) begin : g_int
		logic [INT_WIDTH-1:0] val_d;
		logic                 tag_d;
		always_comb begin
			val_d = int_reg_q[i];
			tag_d = deferred_exception_tag_q[i];
			if (i != 0 && int_wr.en && int_wr.idx == 7'(i)) begin // see RULE_02
				val_d = int_wr.data;
				tag_d = int_wr.tag;
			end
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				int_reg_q[i]                <= INT_RST;
				deferred_exception_tag_q[i] <= 1'b0;
			end else begin
				int_reg_q[i]                <= val_d;
				deferred_exception_tag_q[i] <= tag_d;
			end
		end
	end

	// floating storage; a deferred write lands the special encoding (see RULE_09)
	// 128 entries of 82 bits; legacy state shares entries 8-31 (see RULE_05 RULE_08)
	for (genvar i = 0; i < FLT_ENTRIES; i++) begin : g_flt
		logic [FLT_WIDTH-1:0] val_d;
		always_comb begin
			val_d = float_reg_q[i];
			if (i > 1 && flt_wr.en && flt_wr.idx == 7'(i)) begin // see RULE_06
				val_d = flt_wr.defer ? FLT_DEFER_VAL : flt_wr.data; // see RULE_09
			end
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				float_reg_q[i] <= FLT_RST;
			end else begin
				float_reg_q[i] <= val_d;
			end
		end
	end

	// branch target storage, all entries writable (see RULE_13)
	for (genvar i = 0; i < BT_ENTRIES; i++) begin : g_bt
		logic [BT_WIDTH-1:0] val_d;
		always_comb begin
			val_d = branch_target_reg_q[i];
			if (bt_wr.en && bt_wr.idx == 3'(i)) begin
				val_d = bt_wr.data;
			end
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				branch_target_reg_q[i] <= PTR_RST;
			end else begin
				branch_target_reg_q[i] <= val_d;
			end
		end
	end

	// predicates: entry zero is pinned, writes to it vanish (see RULE_11)
	always_comb begin
		pred_reg_d = pred_reg_q;
		if (prd_wr.en && prd_wr.idx != 6'h00) begin // see RULE_11
			pred_reg_d[prd_wr.idx] = prd_wr.data;
		end
		pred_reg_d[0] = 1'b1; // see RULE_11
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pred_reg_q <= 64'h0000_0000_0000_0001;
		end else begin
			pred_reg_q <= pred_reg_d;
		end
	end

	// read ports: integer and floating constant entries are produced here, not stored; predicate zero is read from its pinned flop
	always_comb begin
		int_rd_d.data = int_reg_q[int_rd_idx];
		int_rd_d.tag  = deferred_exception_tag_q[int_rd_idx];
		if (int_rd_idx == 7'h00) begin // see RULE_02
			int_rd_d.data = INT_RST;
			int_rd_d.tag  = 1'b0;
		end
		unique case (flt_rd_idx)
			7'h00:   flt_rd_d = FLT_POS_ZERO; // see RULE_06
			7'h01:   flt_rd_d = FLT_POS_ONE;  // see RULE_06
			default: flt_rd_d = float_reg_q[flt_rd_idx];
		endcase
		flt_def_d = (flt_rd_d == FLT_DEFER_VAL); // see RULE_09
		prd_rd_d  = pred_reg_q[prd_rd_idx];      // see RULE_11
		bt_rd_d   = branch_target_reg_q[bt_rd_idx];
		// faults are raised, not stored; zero entries stay untouched (see RULE_02)
		int_fault_d = int_wr.en && int_wr.idx == 7'h00;
		flt_fault_d = flt_wr.en && flt_wr.idx <= 7'h01; // see RULE_06
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_rd          <= '0;
			flt_rd          <= FLT_RST;
			flt_rd_deferred <= 1'b0;
			prd_rd          <= 1'b0;
			bt_rd           <= PTR_RST;
			int_write_fault <= 1'b0;
			flt_write_fault <= 1'b0;
		end else begin
			int_rd          <= int_rd_d;
			flt_rd          <= flt_rd_d;
			flt_rd_deferred <= flt_def_d;
			prd_rd          <= prd_rd_d;
			bt_rd           <= bt_rd_d;
			int_write_fault <= int_fault_d;
			flt_write_fault <= flt_fault_d;
		end
	end

	// bundle pointer: no write port, only advance or branch (see RULE_14)
	always_comb begin
		ptr_d = ptr_q;
		if (ptr_branch) begin
			ptr_d = ptr_target;
		end else if (ptr_advance) begin
			// native advances by a bundle; legacy by instruction byte length
			ptr_d = legacy_mode ? ptr_q + PTR_WIDTH'(ptr_bytes)
			                    : ptr_q + PTR_WIDTH'(BUNDLE_BYTES);
		end
		if (!legacy_mode) begin
			ptr_d[BUNDLE_LSBS-1:0] = 4'h0; // see RULE_15
		end // legacy keeps byte address bits (see RULE_16)
	end

	// frame marker: only call, return and alloc reach it (see RULE_17)
	always_comb begin
		current_frame_marker_d = current_frame_marker_q;
		prior_function_state_d = prior_function_state_q;
		if (frame_op.call) begin
			prior_function_state_d = current_frame_marker_q; // see RULE_21
			current_frame_marker_d = '0;    // see RULE_22
			// caller outputs become the whole new frame (see RULE_23)
			current_frame_marker_d[SOF_MSB:SOF_LSB] =
				current_frame_marker_q[SOF_MSB:SOF_LSB] - current_frame_marker_q[SOL_MSB:SOL_LSB];
		end else if (frame_op.ret) begin
			current_frame_marker_d = frame_op.restore;
		end else if (frame_op.alloc) begin
			// alloc resizes the stacked frame, rename bases kept (see RULE_03)
			current_frame_marker_d[SOF_MSB:SOF_LSB] = frame_op.alloc_sof; // see RULE_18
			current_frame_marker_d[SOL_MSB:SOL_LSB] = frame_op.alloc_sol;
			current_frame_marker_d[SOR_MSB:SOR_LSB] = frame_op.alloc_sor;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_q                  <= PTR_RST;
			current_frame_marker_q <= MARK_RST;
			prior_function_state_q <= MARK_RST;
		end else begin
			ptr_q                  <= ptr_d;
			current_frame_marker_q <= current_frame_marker_d;
			prior_function_state_q <= prior_function_state_d;
		end
	end

	// derived views are registered so every output leaves a flip-flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bundle_pointer       <= PTR_RST;
			prior_function_state <= MARK_RST;
			int_rotating_count   <= 8'h00;
			int_rename_base      <= 7'h00;
			float_rename_base    <= 7'h00;
			pred_rename_base     <= 6'h00;
		end else begin
			bundle_pointer       <= ptr_d;
			prior_function_state <= prior_function_state_d;
			int_rotating_count   <= 8'(current_frame_marker_d[SOR_MSB:SOR_LSB] * ROT_PER_SOR); // see RULE_20
			int_rename_base      <= current_frame_marker_d[RRB_INT_MSB:RRB_INT_LSB]; // see RULE_19
			float_rename_base    <= current_frame_marker_d[RRB_FLT_MSB:RRB_FLT_LSB]; // see RULE_07
			pred_rename_base     <= current_frame_marker_d[RRB_PRD_MSB:RRB_PRD_LSB]; // see RULE_12
		end
	end
endmodule : ars_core
`default_nettype wire

// ===== tb/ars_core_props.sv
// Purpose: port timing checks for the register state block
// Assumes: one clock, async active-high reset
// Notes:   answers land one cycle after the sampling edge
`default_nettype none
module ars_core_props
	import ars_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic                   legacy_mode,
	input wire logic [6:0]             int_rd_idx,
	input wire logic [6:0]             flt_rd_idx,
	input wire logic [5:0]             prd_rd_idx,
	input wire ars_pkg::ars_int_wr_t   int_wr,
	input wire ars_pkg::ars_flt_wr_t   flt_wr,
	input wire logic                   ptr_advance,
	input wire logic                   ptr_branch,
	input wire logic [63:0]            ptr_target,
	input wire ars_pkg::ars_frame_op_t frame_op,
	input wire ars_pkg::ars_int_rd_t   int_rd,
	input wire logic [81:0]            flt_rd,
	input wire logic                   prd_rd,
	input wire logic [63:0]            bundle_pointer,
	input wire logic [37:0]            prior_function_state,
	input wire logic [7:0]             int_rotating_count,
	input wire logic [6:0]             int_rename_base,
	input wire logic [6:0]             float_rename_base,
	input wire logic [5:0]             pred_rename_base,
	input wire logic                   int_write_fault,
	input wire logic                   flt_write_fault
);
	timeunit 1ns;
	timeprecision 100ps;
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_int_fault; int_wr.en && int_wr.idx == 7'h00 |=> int_write_fault; endproperty
	a_int_fault: assert property (p_int_fault) else $error("no fault on int zero write");
	property p_int_quiet; !int_wr.en |=> !int_write_fault; endproperty
	a_int_quiet: assert property (p_int_quiet) else $error("stray int fault");
	property p_int_zero; int_rd_idx == 7'h00 |=> int_rd.data == 64'h0000_0000_0000_0000; endproperty
	a_int_zero: assert property (p_int_zero) else $error("int zero not zero");
	property p_flt_fault; flt_wr.en && flt_wr.idx <= 7'h01 |=> flt_write_fault; endproperty
	a_flt_fault: assert property (p_flt_fault) else $error("no float fault");
	property p_flt_one; flt_rd_idx == 7'h01 |=> flt_rd == FLT_POS_ONE; endproperty
	a_flt_one: assert property (p_flt_one) else $error("float one wrong");
	property p_prd_true; prd_rd_idx == 6'h00 |=> prd_rd; endproperty
	a_prd_true: assert property (p_prd_true) else $error("pred zero not one");
	property p_ptr_hold; !ptr_advance && !ptr_branch |=> $stable(bundle_pointer); endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
	property p_ptr_native;
		ptr_advance && !ptr_branch && !legacy_mode |=>
			bundle_pointer == $past(bundle_pointer) + 64'h0000_0000_0000_0010;
	endproperty
	a_ptr_native: assert property (p_ptr_native) else $error("bad native step");
	property p_ptr_jump; ptr_branch && legacy_mode |=> bundle_pointer == $past(ptr_target); endproperty
	a_ptr_jump: assert property (p_ptr_jump) else $error("bad legacy branch");
	property p_call_new;
		frame_op.call |=> {int_rename_base, float_rename_base, pred_rename_base} == 20'h0_0000
			&& int_rotating_count == 8'h00;
	endproperty
	a_call_new: assert property (p_call_new) else $error("call frame not cleared");
	property p_call_save;
		frame_op.call |=> prior_function_state[24:18] == $past(int_rename_base)
			&& prior_function_state[37:32] == $past(pred_rename_base);
	endproperty
	a_call_save: assert property (p_call_save) else $error("marker not saved");
endmodule : ars_core_props
bind ars_core ars_core_props chk_u (.clk, .rst, .legacy_mode, .int_rd_idx, .flt_rd_idx,
	.prd_rd_idx, .int_wr, .flt_wr, .ptr_advance, .ptr_branch, .ptr_target, .frame_op,
	.int_rd, .flt_rd, .prd_rd, .bundle_pointer, .prior_function_state, .int_rotating_count,
	.int_rename_base, .float_rename_base, .pred_rename_base, .int_write_fault,
	.flt_write_fault);
`default_nettype wire

// ===== tb/ars_pipe_model.sv
// Purpose: issue side of the execution pipeline
// Assumes: callers set requests one step after an edge
// Notes:   requests last one cycle, read indexes stay put
`default_nettype none
module ars_pipe_model
	import ars_pkg::*;
(
	input  wire logic                   clk,
	output var logic                    legacy_mode,
	output var logic [6:0]              int_rd_idx,
	output var logic [6:0]              flt_rd_idx,
	output var logic [5:0]              prd_rd_idx,
	output var logic [2:0]              bt_rd_idx,
	output var ars_pkg::ars_int_wr_t    int_wr,
	output var ars_pkg::ars_flt_wr_t    flt_wr,
	output var ars_pkg::ars_prd_wr_t    prd_wr,
	output var ars_pkg::ars_bt_wr_t     bt_wr,
	output var logic                    ptr_advance,
	output var logic [3:0]              ptr_bytes,
	output var logic                    ptr_branch,
	output var logic [63:0]             ptr_target,
	output var ars_pkg::ars_frame_op_t  frame_op
);
	timeunit 1ns;
	timeprecision 100ps;
	// quiet at time zero so reset sees a clean pipe
	initial begin
		{legacy_mode, int_rd_idx, flt_rd_idx, prd_rd_idx, bt_rd_idx} = '0;
		idle();
	end
	task automatic idle();
		{int_wr, flt_wr, prd_wr, bt_wr, frame_op, ptr_advance, ptr_bytes, ptr_branch, ptr_target} = '0;
	endtask : idle
	// requests drop after one edge, so a write is never taken twice
	task automatic tick();
		@(posedge clk);
		#1;
		idle();
	endtask : tick
endmodule : ars_pipe_model
`default_nettype wire

// ===== tb/application_register_state_tb_top.sv
// Purpose: self-checking bench for the register state block
// Assumes: requests change one step after a rising edge
// Notes:   answers judged one step after the taking edge
`default_nettype none
module application_register_state_tb_top;
	import ars_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	int   num_errors = 0;
	int   n_tests = 0;
	logic legacy_mode, ptr_advance, ptr_branch, flt_rd_deferred, prd_rd;
	logic int_write_fault, flt_write_fault;
	logic [6:0]  int_rd_idx, flt_rd_idx, int_rename_base, float_rename_base;
	logic [5:0]  prd_rd_idx, pred_rename_base;
	logic [2:0]  bt_rd_idx;
	logic [3:0]  ptr_bytes;
	logic [7:0]  int_rotating_count;
	logic [37:0] prior_function_state;
	logic [63:0] ptr_target, bt_rd, bundle_pointer;
	logic [81:0] flt_rd;
	ars_int_wr_t int_wr;
	ars_flt_wr_t flt_wr;
	ars_prd_wr_t prd_wr;
	ars_bt_wr_t  bt_wr;
	ars_int_rd_t int_rd;
	ars_frame_op_t frame_op;
	always #5 clk = ~clk;
	ars_pipe_model pipe_u (.clk, .legacy_mode, .int_rd_idx, .flt_rd_idx, .prd_rd_idx,
		.bt_rd_idx, .int_wr, .flt_wr, .prd_wr, .bt_wr, .ptr_advance, .ptr_bytes,
		.ptr_branch, .ptr_target, .frame_op);
	ars_core dut_u (.clk, .rst, .legacy_mode, .int_rd_idx, .flt_rd_idx, .prd_rd_idx,
		.bt_rd_idx, .int_wr, .flt_wr, .prd_wr, .bt_wr, .ptr_advance, .ptr_bytes,
		.ptr_branch, .ptr_target, .frame_op, .int_rd, .flt_rd, .flt_rd_deferred, .prd_rd,
		.bt_rd, .bundle_pointer, .prior_function_state, .int_rotating_count,
		.int_rename_base, .float_rename_base, .pred_rename_base, .int_write_fault,
		.flt_write_fault);
	// widest result is the float entry, narrower ones zero-extend
	task automatic chk(input logic [81:0] got, input logic [81:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	// zero-entry write rides along with a read of entry 5
	task automatic s_int();
		pipe_u.int_wr = '{1'b1, 7'h05, 64'h1234_5678_9abc_def0, 1'b1};
		pipe_u.tick();
		pipe_u.int_rd_idx = 7'h05;
		pipe_u.int_wr = '{1'b1, 7'h00, 64'hffff_ffff_ffff_ffff, 1'b0};
		pipe_u.tick();
		chk(int_rd, {64'h1234_5678_9abc_def0, 1'b1});
		chk(int_write_fault, 1'b1);
		pipe_u.int_rd_idx = 7'h00;
		pipe_u.int_wr = '{1'b1, 7'h7f, 64'h0000_0000_0000_0077, 1'b0};
		pipe_u.tick();
		chk(int_rd, '0);
		chk(int_write_fault, 1'b0);
		pipe_u.int_rd_idx = 7'h7f;
		pipe_u.tick();
		chk(int_rd, {64'h0000_0000_0000_0077, 1'b0});
	endtask : s_int
	task automatic s_flt();
		pipe_u.flt_wr = '{1'b1, 7'h28, 82'h0_4000_c000_0000_0000_0000, 1'b0};
		pipe_u.tick();
		pipe_u.flt_rd_idx = 7'h28;
		pipe_u.flt_wr = '{1'b1, 7'h7f, 82'h0_0000_0000_0000_0000_0005, 1'b1};
		pipe_u.tick();
		chk(flt_rd, 82'h0_4000_c000_0000_0000_0000);
		chk(flt_rd_deferred, 1'b0);
		pipe_u.flt_rd_idx = 7'h7f;
		pipe_u.flt_wr = '{1'b1, 7'h01, 82'h0_0000_0000_0000_0000_0005, 1'b0};
		pipe_u.tick();
		chk(flt_rd, FLT_DEFER_VAL);
		chk(flt_rd_deferred, 1'b1);
		chk(flt_write_fault, 1'b1);
		pipe_u.flt_rd_idx = 7'h01;
		pipe_u.flt_wr = '{1'b1, 7'h00, 82'h0_0000_0000_0000_0000_0005, 1'b0};
		pipe_u.tick();
		chk(flt_rd, FLT_POS_ONE);
		chk(flt_write_fault, 1'b1);
		pipe_u.flt_rd_idx = 7'h00;
		pipe_u.tick();
		chk(flt_rd, FLT_POS_ZERO);
		chk(flt_write_fault, 1'b0);
	endtask : s_flt
	task automatic s_prd();
		pipe_u.prd_wr = '{1'b1, 6'h00, 1'b0};
		pipe_u.bt_wr = '{1'b1, 3'h7, 64'hffff_0000_1234_5670};
		pipe_u.tick();
		pipe_u.prd_rd_idx = 6'h00;
		pipe_u.bt_rd_idx = 3'h7;
		pipe_u.prd_wr = '{1'b1, 6'h3f, 1'b1};
		pipe_u.tick();
		chk(prd_rd, 1'b1);
		chk({int_write_fault, flt_write_fault}, 2'b00);
		chk(bt_rd, 64'hffff_0000_1234_5670);
		pipe_u.prd_rd_idx = 6'h3f;
		pipe_u.tick();
		chk(prd_rd, 1'b1);
	endtask : s_prd
	// branch beats a same-cycle advance; native step ignores the byte count
	task automatic s_ptr();
		pipe_u.ptr_branch = 1'b1;
		pipe_u.ptr_advance = 1'b1;
		pipe_u.ptr_target = 64'h0000_0000_0000_1230;
		pipe_u.tick();
		chk(bundle_pointer, 64'h0000_0000_0000_1230);
		pipe_u.ptr_advance = 1'b1;
		pipe_u.ptr_bytes = 4'h3;
		pipe_u.tick();
		chk(bundle_pointer, 64'h0000_0000_0000_1240);
		pipe_u.tick();
		chk(bundle_pointer, 64'h0000_0000_0000_1240);
		pipe_u.legacy_mode = 1'b1;
		pipe_u.ptr_advance = 1'b1;
		pipe_u.ptr_bytes = 4'h3;
		pipe_u.tick();
		chk(bundle_pointer, 64'h0000_0000_0000_1243);
		// a legacy branch keeps the byte address; the branch that leaves legacy mode lands bundle-aligned
		pipe_u.ptr_branch = 1'b1;
		pipe_u.ptr_target = 64'h0000_0000_0000_2005;
		pipe_u.tick();
		chk(bundle_pointer, 64'h0000_0000_0000_2005);
		pipe_u.legacy_mode = 1'b0;
		pipe_u.ptr_branch = 1'b1;
		pipe_u.ptr_target = 64'h0000_0000_0000_3007;
		pipe_u.tick();
		chk(bundle_pointer, 64'h0000_0000_0000_3000);
	endtask : s_ptr
	task automatic s_frame();
		pipe_u.frame_op = '{1'b0, 1'b1, {6'h07, 7'h06, 7'h05, 4'h2, 7'h04, 7'h0a},
			7'h00, 7'h00, 4'h0, 1'b0};
		pipe_u.tick();
		chk({int_rename_base, float_rename_base, pred_rename_base}, {7'h05, 7'h06, 6'h07});
		chk(int_rotating_count, 8'h10);
		pipe_u.frame_op = '{1'b0, 1'b0, 38'h00_0000_0000, 7'h14, 7'h08, 4'h3, 1'b1};
		pipe_u.tick();
		chk(int_rotating_count, 8'h18);
		pipe_u.frame_op.call = 1'b1;
		pipe_u.tick();
		chk(prior_function_state, {6'h07, 7'h06, 7'h05, 4'h3, 7'h08, 7'h14});
		chk({int_rename_base, float_rename_base, pred_rename_base}, '0);
		pipe_u.frame_op.call = 1'b1;
		pipe_u.tick();
		chk(prior_function_state, 38'h00_0000_000c);
	endtask : s_frame
	initial begin
		repeat (4) @(posedge clk);
		#1;
		chk(bundle_pointer, '0);
		rst = 1'b0;
		s_int();
		s_flt();
		s_prd();
		s_ptr();
		s_frame();
		wrap_up();
	end
	// a hang is cut short and counted
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
endmodule : application_register_state_tb_top
`default_nettype wire
